// File: dv/tb_top.sv
// Bench for the compositor: registers, pixel path, status flags.
// Assumes vcs_rx as the receiving side of the pixel output.
`timescale 1ns/1ps
module tb_top
  import vcs_pkg::*;
;
  logic        sys_clk, rst, cyc, stb, we, pv, pin, f2, vb, oval, ack, irq1, irq2;
  logic [7:0]  adr;
  logic [31:0] wdat, dat, img, ovl, rdat, al0, al1, key, msk, clp, enh, ov;
  logic [11:0] li, pi;
  logic [4:0]  ev;
  logic [1:0]  ren;
  wire  [31:0] pix, got;
  int          bad_count, n_compared, cyc_cnt;

  vcs_top dut
  (
    .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack), .pix_valid(pv),
    .pix_in_image(pin), .img_y0(img[7:0]), .img_y1(img[15:8]), .img_u(img[23:16]), .img_v(img[31:24]),
    .ovl_y0(ovl[7:0]), .ovl_y1(ovl[15:8]), .ovl_u(ovl[23:16]), .ovl_v(ovl[31:24]), .out_valid(oval),
    .out_y0(pix[7:0]), .out_y1(pix[15:8]), .out_u(pix[23:16]), .out_v(pix[31:24]), .line_index(li),
    .pixel_index(pi), .second_field_active_in(f2), .vertical_blank_active_in(vb), .sav_pulse(ev[0]), .overlap_done(ev[1]),
    .byte_sent(ev[2]), .last_byte_sent(ev[3]), .highway_late(ev[4]), .buf_read_en(ren),
    .buf1_irq(irq1), .buf2_irq(irq2)
  );
  vcs_rx rx (.sys_clk(sys_clk), .out_valid(oval), .pix(pix), .got(got));

  // Expected blend; arithmetic shift keeps the sign of the difference
  function automatic logic [7:0] bl(input logic [7:0] o, input logic [7:0] i, input logic [7:0] a);
    logic signed [17:0] p;
    p = $signed({11'h0, a[6:0]}) * ($signed({10'h0, o}) - $signed({10'h0, i}));
    bl = a[7] ? o : 8'(i + 8'(p >>> 7));
  endfunction
  function automatic logic [7:0] cl(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi,
                                    input logic act);
    cl = !act ? v : (v <= lo) ? lo : (v >= hi) ? hi : v;
  endfunction
  function automatic logic km(input logic [7:0] o, input logic [7:0] k, input logic [2:0] m);
    km = ((o ^ k) & (8'hff << m)) == 8'h00;
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  // Classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
      @(posedge sys_clk);
    while (ack !== 1'b1);
    rdat = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic pulse(input int b);
    @(posedge sys_clk);
    ev[b] <= 1'b1;
    @(posedge sys_clk);
    ev <= 5'h00;
  endtask
  // One pair in, result seen by the receiver four edges later
  task automatic px(input logic [31:0] o, input logic [31:0] im, input logic inn);
    logic       k0, k1, ch;
    logic [7:0] a0, a1, lo, hi, lc, hc;
    ch = enh[ENH_ON] & enh[ENH_KEY] & km(o[23:16], key[15:8], msk[10:8]) & km(o[31:24], key[23:16], msk[10:8]);
    k0 = ch & km(o[7:0], key[7:0], msk[2:0]);
    k1 = ch & km(o[15:8], key[7:0], msk[2:0]);
    a0 = k0 ? 8'h00 : o[16] ? al1[7:0] : al0[7:0];
    a1 = k1 ? 8'h00 : o[24] ? al1[7:0] : al0[7:0];
    // Coarse blending keeps only quarter steps of the level
    if (!(enh[ENH_ON] & enh[ENH_BLEND]))
    begin
      a0[6:0] = {a0[6:5], 5'h00};
      a1[6:0] = {a1[6:5], 5'h00};
    end
    {hc, lc, hi, lo} = (enh[ENH_CLIP] && clp != 0) ? clp : {FIXED_CEIL, FIXED_FLOOR, FIXED_CEIL, FIXED_FLOOR};
    @(posedge sys_clk);
    pv <= 1'b1;
    img <= im;
    ovl <= o;
    pin <= inn;
    @(posedge sys_clk);
    pv <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(got, {cl(bl(o[31:24], im[31:24], a0), lc, hc, inn), cl(bl(o[23:16], im[23:16], a0), lc, hc, inn),
              cl(bl(o[15:8], im[15:8], a1), lo, hi, inn), cl(bl(o[7:0], im[7:0], a0), lo, hi, inn)});
  endtask

  task stop_test;
    if (bad_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Clock, 8 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Hang guard, well above the expected run
  always @(posedge sys_clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      bad_count++;
      stop_test();
    end
  end

  // Main sequence
  initial
  begin
    {cyc, stb, we, pv, pin, f2, vb, adr, wdat, img, ovl, ev} = '0;
    li = 12'h0ab;
    pi = 12'h345;
    clp = 32'hf010eb10;
    void'($urandom(95));
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rc(OFF_CLIP, 32'hf010eb10);
    rc(OFF_STATUS, 32'h10);
    rc(8'hfc, 32'h0);
    for (int t = 0; t < 24; t++)
    begin
      al0 = $urandom;
      al1 = $urandom;
      key = $urandom;
      enh = $urandom & 32'hf;
      msk = {21'h0, 3'($urandom_range(4, 0)), 5'h0, 3'($urandom_range(4, 0))};
      clp = (t == 0) ? 32'hff00ff00 : (t % 3 == 1) ? 32'h0 : ($urandom & 32'h7f7f7f7f) | 32'h80008000;
      wb(1'b1, OFF_ALPHA_ZERO, al0);
      wb(1'b1, OFF_ALPHA_ONE, al1);
      wb(1'b1, OFF_KEY_VALUES, key);
      wb(1'b1, OFF_KEY_MASKS, msk);
      wb(1'b1, OFF_CLIP, clp);
      wb(1'b1, OFF_ENH_CTL, enh);
      for (int j = 0; j < 4; j++)
      begin
        ov = $urandom;
        if (j[0])
          ov = {key[23:16], key[15:8], ov[15:8], key[7:0]} ^ (ov & {{2{8'h0f >> (4 - msk[10:8])}}, 8'h00, 8'h0f >> (4 - msk[2:0])});
        px(ov, $urandom, 1'($urandom));
      end
    end
    pulse(4);
    rc(OFF_STATUS, 32'h30);
    repeat (5) @(posedge sys_clk);
    rc(OFF_STATUS, 32'h30);
    wb(1'b1, OFF_CTL, 32'h40);
    rc(OFF_STATUS, 32'h10);
    wb(1'b1, OFF_CTL, 32'h200);
    pulse(1);
    rc(OFF_STATUS, 32'h11);
    chk(irq1, 1'b1);
    pulse(0);
    rc(OFF_STATUS, 32'h15);
    wb(1'b1, OFF_CTL, 32'h290);
    rc(OFF_STATUS, 32'h10);
    wb(1'b1, OFF_YTHR, 32'h123);
    li <= 12'h123;
    wb(1'b1, OFF_CTL, 32'h0);
    li <= 12'h0ab;
    rc(OFF_STATUS, 32'h18);
    wb(1'b1, OFF_CTL, 32'h100);
    f2 <= 1'b1;
    vb <= 1'b1;
    rc(OFF_STATUS, 32'hd0);
    rc(OFF_POSITION, 32'h0ab345);
    wb(1'b1, OFF_CTL, 32'h638);
    rc(OFF_STATUS, 32'h10);
    for (int b = 0; b < 4; b++)
      pulse(2);
    rc(OFF_POSITION, 32'h4);
    chk(ren, 2'b11);
    pulse(3);
    rc(OFF_STATUS, 32'h51);
    chk({ren, irq1, irq2}, 4'ha);
    pulse(3);
    rc(OFF_STATUS, 32'h57);
    chk({ren, irq2}, 3'h1);
    wb(1'b1, OFF_CTL, 32'hb9);
    pulse(3);
    wb(1'b0, OFF_STATUS, 32'h0);
    chk(rdat[0], 1'b1);
    stop_test();
  end
endmodule

// File: dv/vcs_rx.sv
// Video receiver model: keeps the last composited pair.
// Assumes out_* and out_valid are registered on sys_clk.
`timescale 1ns/1ps
module vcs_rx
(
  input  wire logic        sys_clk,
  input  wire logic        out_valid,
  input  wire logic [31:0] pix,
  output logic      [31:0] got
);
  // Capture only flagged pairs, cycles without out_valid are ignored
  always_ff @(posedge sys_clk)
  begin
    if (out_valid)
      got <= pix;
  end
endmodule

// File: rtl/vcs_blend.sv
// One-component alpha blender, purely combinational.
// Assumes alpha is already chosen and forced to zero for keyed pixels.
`timescale 1ns/1ps
module vcs_blend
  import vcs_pkg::*;
(
  input  wire logic [7:0] ovl,
  input  wire logic [7:0] img,
  input  wire logic [7:0] alpha,
  input  wire logic       fine,
  output logic      [7:0] res
);
  logic        [6:0]  a7;
  logic signed [8:0]  diff;
  logic signed [16:0] prod;
  logic        [9:0]  sum;

  // Coarse mode keeps only quarter steps of the level
  assign a7   = fine ? alpha[6:0] : {alpha[6:5], 5'h00}; // RQ25 RQ3
  assign diff = $signed({1'b0, ovl}) - $signed({1'b0, img});
  // Product stays signed so negative differences shift correctly
  assign prod = $signed({1'b0, a7}) * diff; // RQ4
  assign sum  = prod[16:7] + {2'h0, img}; // RQ4
  // Top bit gives full overlay; result never leaves 0..255
  assign res  = alpha[7] ? ovl : sum[7:0]; // RQ3
endmodule

// File: rtl/vcs_clip.sv
// One-component output clipper, purely combinational.
// Assumes the caller decides whether the sample lies in the picture.
`timescale 1ns/1ps
module vcs_clip
  import vcs_pkg::*;
(
  input  wire logic [7:0] val,
  input  wire logic [7:0] lo,
  input  wire logic [7:0] hi,
  input  wire logic       active,
  output logic      [7:0] res
);
  // Blanking passes untouched; limits of 0 and 255 are a no-op
  always_comb
  begin
    res = val;
    if (active && val <= lo)
      res = lo; // RQ11
    else if (active && val >= hi)
      res = hi; // RQ11
  end
endmodule

// File: rtl/vcs_pkg.sv
// Shared constants for the video overlay compositor and status block.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package vcs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_ALPHA_ZERO = 8'h00;
  localparam logic [7:0] OFF_ALPHA_ONE  = 8'h04;
  localparam logic [7:0] OFF_KEY_VALUES = 8'h08;
  localparam logic [7:0] OFF_KEY_MASKS  = 8'h0c;
  localparam logic [7:0] OFF_CLIP       = 8'h10;
  localparam logic [7:0] OFF_ENH_CTL    = 8'h14;
  localparam logic [7:0] OFF_CTL        = 8'h18;
  localparam logic [7:0] OFF_YTHR       = 8'h1c;
  localparam logic [7:0] OFF_STATUS     = 8'h20;
  localparam logic [7:0] OFF_POSITION   = 8'h24;
  // Enhanced control bits
  localparam int ENH_ON    = 0;
  localparam int ENH_KEY   = 1;
  localparam int ENH_CLIP  = 2;
  localparam int ENH_BLEND = 3;
  // Control register fields
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_B1_ACK   = 4;
  localparam int CTL_B2_ACK   = 5;
  localparam int CTL_BANDWIDTH_ERROR_CLEAR  = 6;
  localparam int CTL_UNDERRUN_CLEAR = 7;
  localparam int CTL_YTR_ACK  = 8;
  localparam int CTL_B1_IEN   = 9;
  localparam int CTL_B2_IEN   = 10;
  // Status bit positions
  localparam int ST_B1    = 0;
  localparam int ST_B2    = 1;
  localparam int ST_REFILL_UNDERRUN  = 2;
  localparam int ST_YTR   = 3;
  localparam int ST_UNIT  = 4;
  localparam int ST_HBE   = 5;
  localparam int ST_FLD2  = 6;
  localparam int ST_VBLK  = 7;
  // Mask field positions, each a 3-bit count
  localparam int MSK_Y_LSB  = 0;
  localparam int MSK_UV_LSB = 8;
  localparam logic [2:0] MASK_MAX = 3'h4;
  // Reset values and fixed limits
  localparam logic [31:0] CLIP_RESET  = 32'hf010eb10;
  localparam logic [7:0]  FIXED_FLOOR = 8'h10;
  localparam logic [7:0]  FIXED_CEIL  = 8'hf0;
  localparam logic        UNIT_TYPE   = 1'b1;
  // Operating modes
  localparam logic [3:0] MODE_STREAM = 4'h8;
  localparam logic [3:0] MODE_MSG    = 4'h9;

  function automatic logic is_refresh(input logic [3:0] m);
    is_refresh = ~m[3];
  endfunction
endpackage

// File: rtl/vcs_top.sv
// Overlay compositor with keying, blending, clipping and status flags.
// Assumes timing pulses from the sync generator and a Wishbone master.
// Notes on behaviour
// RQ1 - Alpha bit of U picks level for Y0, of V for Y1; 0/1 pick registers.
// RQ2 - U-byte alpha drives U, V and Y0; V-byte alpha drives only Y1.
// RQ3 - Low 7 bits are 128 levels; bit 7 set gives pure overlay.
// RQ4 - Blend is image plus alpha times difference, shifted right by 7.
// RQ5 - Keying needs both enhanced enable and key enable.
// RQ6 - Three 8-bit keys compared against overlay Y, U, V.
// RQ7 - Full unmasked match makes the pixel transparent, image shows.
// RQ8 - Luma and chroma mask counts ignore 0..4 low bits.
// RQ9 - Clipping enable applies programmed clipping as last stage.
// RQ10 - Clip only inside picture area; blanking passes unclipped.
// RQ11 - Values at or beyond a limit are forced to that limit.
// RQ12 - Clip limits reset to 16/235 luma and 16/240 chroma.
// RQ13 - Clip disabled means fixed 16..240; programmed 0/255 means none.
// RQ14 - Status bit 4 is a fixed unit type, apart from bit 5.
// RQ15 - Report line and pixel index, or 24-bit byte count in data modes.
// RQ16 - Refresh uses buffer one; empty set when overlap area completes.
// RQ17 - Refresh: unacknowledged buffer one at next start sets underrun.
// RQ18 - Streaming: empty and stop at last byte; underrun if other unacked.
// RQ19 - Message mode sets buffer one empty when message is sent.
// RQ20 - One interrupt per buffer when empty and its enable set.
// RQ21 - Late highway data sets bandwidth error in every mode.
// RQ22 - Refresh: line counter equal to threshold sets threshold flag; code sets it only outside vertical blank.
// RQ23 - Field bit shows active buffer or field two; vertical_blank_active only in refresh.
// RQ24 - Writing one to error or underrun acknowledge clears that flag.
// RQ25 - Without enhanced enable and full blending use quarter steps.
// RQ26 - Flags stay set until their acknowledge, a new event wins.
//
// Our own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module vcs_top
  import vcs_pkg::*;
#(
  parameter int CNT_W = 12
)
(
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             pix_valid,
  input  wire logic             pix_in_image,
  input  wire logic [7:0]       img_y0,
  input  wire logic [7:0]       img_y1,
  input  wire logic [7:0]       img_u,
  input  wire logic [7:0]       img_v,
  input  wire logic [7:0]       ovl_y0,
  input  wire logic [7:0]       ovl_y1,
  input  wire logic [7:0]       ovl_u,
  input  wire logic [7:0]       ovl_v,
  output logic                  out_valid,
  output logic      [7:0]       out_y0,
  output logic      [7:0]       out_y1,
  output logic      [7:0]       out_u,
  output logic      [7:0]       out_v,
  input  wire logic [CNT_W-1:0] line_index,
  input  wire logic [CNT_W-1:0] pixel_index,
  input  wire logic             second_field_active_in,
  input  wire logic             vertical_blank_active_in,
  input  wire logic             sav_pulse,
  input  wire logic             overlap_done,
  input  wire logic             byte_sent,
  input  wire logic             last_byte_sent,
  input  wire logic             highway_late,
  output logic      [1:0]       buf_read_en,
  output logic                  buf1_irq,
  output logic                  buf2_irq
);
  logic [7:0]  alpha0_r;
  logic [7:0]  alpha1_r;
  logic [31:0] key_r;
  logic [31:0] mask_r;
  logic [31:0] clip_r;
  logic [3:0]  enh_r;
  logic [31:0] ctl_r;
  logic [CNT_W-1:0] ythr_r;
  logic        b1_r;
  logic        b2_r;
  logic        refill_underrun_r;
  logic        ytr_r;
  logic        hbe_r;
  logic        act_r;
  logic [23:0] bcnt_r;
  logic        wr;
  logic        wr_ctl;
  logic [3:0]  mode;
  logic        refresh;
  logic        stream;
  logic        data_mode;
  logic        other_empty;
  logic        b1_set;
  logic        b2_set;
  logic        refill_underrun_set;
  logic        ytr_set;
  logic [7:0]  status;
  logic [23:0] position;

  // Byte-lane merge, so partial writes keep untouched bytes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++)
      old[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    merge = old;
  endfunction

  // Compare mask with up to four low bits ignored; larger counts saturate
  function automatic logic [7:0] key_mask(input logic [2:0] n);
    key_mask = 8'hff << ((n > MASK_MAX) ? MASK_MAX : n); // RQ8
  endfunction

  function automatic logic key_hit(input logic [7:0] a, input logic [7:0] k,
                                   input logic [7:0] m);
    key_hit = ((a ^ k) & m) == 8'h00;
  endfunction

  assign mode      = ctl_r[CTL_MODE_LSB +: 4];
  assign refresh   = is_refresh(mode);
  assign stream    = (mode == MODE_STREAM);
  assign data_mode = stream || (mode == MODE_MSG);

  // Single-wait-state slave: ack rises one cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  // Writes land on the edge where the master sees ack
  assign wr     = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign wr_ctl = wr && (wb_adr_i == OFF_CTL);

  // Software-written configuration
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      alpha0_r <= 8'h00;
      alpha1_r <= 8'h00;
      key_r    <= 32'h00000000;
      mask_r   <= 32'h00000000;
      clip_r   <= CLIP_RESET; // RQ12
      enh_r    <= 4'h0;
      ctl_r    <= 32'h00000000;
      ythr_r   <= '0;
    end
    else if (wr)
    begin
      case (wb_adr_i)
        OFF_ALPHA_ZERO: alpha0_r <= wb_sel_i[0] ? wb_dat_i[7:0] : alpha0_r;
        OFF_ALPHA_ONE:  alpha1_r <= wb_sel_i[0] ? wb_dat_i[7:0] : alpha1_r;
        OFF_KEY_VALUES: key_r    <= merge(key_r, {8'h00, wb_dat_i[23:0]}, wb_sel_i);
        OFF_KEY_MASKS:  mask_r   <= merge(mask_r, wb_dat_i & 32'h00000707, wb_sel_i);
        OFF_CLIP:       clip_r   <= merge(clip_r, wb_dat_i, wb_sel_i);
        OFF_ENH_CTL:    enh_r    <= wb_sel_i[0] ? wb_dat_i[3:0] : enh_r;
        // Acknowledge bits are strobes and never stored
        OFF_CTL:        ctl_r    <= merge(ctl_r, wb_dat_i & 32'h0000060f, wb_sel_i);
        OFF_YTHR:       ythr_r   <= CNT_W'(merge({{(32-CNT_W){1'b0}}, ythr_r}, wb_dat_i, wb_sel_i));
        default:        ctl_r    <= ctl_r;
      endcase
    end
  end

  // Status word; unit bit is a constant, not a copy of the error flag
  assign status = {refresh && vertical_blank_active_in, // RQ23
                   stream ? act_r : (refresh && second_field_active_in), // RQ23
                   hbe_r, UNIT_TYPE, ytr_r, refill_underrun_r, b2_r, b1_r}; // RQ14

  // Byte count in data modes, raster position otherwise
  assign position = data_mode ? bcnt_r : // RQ15
                    {12'(line_index), 12'(pixel_index)}; // RQ15

  // Read data registered with ack; unmapped addresses read zero
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      wb_dat_o <= 32'h00000000;
    else if (wb_cyc_i && wb_stb_i && !wb_ack_o)
    begin
      case (wb_adr_i)
        OFF_ALPHA_ZERO: wb_dat_o <= {24'h000000, alpha0_r};
        OFF_ALPHA_ONE:  wb_dat_o <= {24'h000000, alpha1_r};
        OFF_KEY_VALUES: wb_dat_o <= key_r;
        OFF_KEY_MASKS:  wb_dat_o <= mask_r;
        OFF_CLIP:       wb_dat_o <= clip_r;
        OFF_ENH_CTL:    wb_dat_o <= {28'h0000000, enh_r};
        OFF_CTL:        wb_dat_o <= ctl_r;
        OFF_YTHR:       wb_dat_o <= {{(32-CNT_W){1'b0}}, ythr_r};
        OFF_STATUS:     wb_dat_o <= {24'h000000, status};
        OFF_POSITION:   wb_dat_o <= {8'h00, position};
        default:        wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // Flag raising conditions
  assign other_empty = act_r ? b1_r : b2_r;
  assign b1_set   = (refresh && overlap_done) || // RQ16
                    (mode == MODE_MSG && last_byte_sent) || // RQ19
                    (stream && last_byte_sent && !act_r); // RQ18
  assign b2_set   = stream && last_byte_sent && act_r; // RQ18
  assign refill_underrun_set = (refresh && sav_pulse && b1_r) || // RQ17
                    (stream && last_byte_sent && other_empty); // RQ18
  assign ytr_set  = refresh && !vertical_blank_active_in && (line_index == ythr_r); // RQ22

  // Sticky flags: a new event beats a same-cycle acknowledge
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      b1_r   <= 1'b0;
      b2_r   <= 1'b0;
      refill_underrun_r <= 1'b0;
      ytr_r  <= 1'b0;
      hbe_r  <= 1'b0;
    end
    else
    begin
      b1_r   <= b1_set || (b1_r && !(wr_ctl && wb_sel_i[0] && wb_dat_i[CTL_B1_ACK])); // RQ26
      b2_r   <= b2_set || (b2_r && !(wr_ctl && wb_sel_i[0] && wb_dat_i[CTL_B2_ACK])); // RQ26
      refill_underrun_r <= refill_underrun_set || (refill_underrun_r && !(wr_ctl && wb_sel_i[0] && wb_dat_i[CTL_UNDERRUN_CLEAR])); // RQ24
      ytr_r  <= ytr_set || (ytr_r && !(wr_ctl && wb_sel_i[1] && wb_dat_i[CTL_YTR_ACK])); // RQ26
      hbe_r  <= highway_late || (hbe_r && !(wr_ctl && wb_sel_i[0] && wb_dat_i[CTL_BANDWIDTH_ERROR_CLEAR])); // RQ21 RQ24
    end
  end

  // Active buffer only moves when the other one was acknowledged
  always_ff @(posedge sys_clk)
  begin
    if (rst || !stream)
      act_r <= 1'b0;
    else if (last_byte_sent && !other_empty)
      act_r <= ~act_r; // RQ18
  end

  // Byte counter restarts with each buffer
  always_ff @(posedge sys_clk)
  begin
    if (rst || !data_mode || last_byte_sent)
      bcnt_r <= 24'h000000;
    else if (byte_sent)
      bcnt_r <= bcnt_r + 24'h000001; // RQ15
  end

  // Emptied buffers are not read; buffer two only streams
  assign buf_read_en[0] = !b1_r; // RQ18
  assign buf_read_en[1] = stream && !b2_r; // RQ16
  assign buf1_irq = b1_r && ctl_r[CTL_B1_IEN]; // RQ20
  assign buf2_irq = b2_r && ctl_r[CTL_B2_IEN]; // RQ20

  // Stage 1: keying and alpha selection
  logic       s1_v_r;
  logic       s1_img_r;
  logic [7:0] s1_iy0_r, s1_iy1_r, s1_iu_r, s1_iv_r;
  logic [7:0] s1_oy0_r, s1_oy1_r, s1_ou_r, s1_ov_r;
  logic [7:0] s1_ac_r;
  logic [7:0] s1_a1_r;
  logic       key_on;
  logic       hit0;
  logic       hit1;
  logic [7:0] mk_y;
  logic [7:0] mk_c;

  assign key_on = enh_r[ENH_ON] && enh_r[ENH_KEY]; // RQ5
  assign mk_y   = key_mask(mask_r[MSK_Y_LSB +: 3]); // RQ8
  assign mk_c   = key_mask(mask_r[MSK_UV_LSB +: 3]); // RQ8
  assign hit0   = key_on && key_hit(ovl_y0, key_r[7:0], mk_y) && // RQ6
                  key_hit(ovl_u, key_r[15:8], mk_c) && key_hit(ovl_v, key_r[23:16], mk_c);
  assign hit1   = key_on && key_hit(ovl_y1, key_r[7:0], mk_y) &&
                  key_hit(ovl_u, key_r[15:8], mk_c) && key_hit(ovl_v, key_r[23:16], mk_c);

  // Keyed pixels get alpha zero, which yields the pure image
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s1_v_r  <= 1'b0;
      s1_ac_r <= 8'h00;
      s1_a1_r <= 8'h00;
    end
    else
    begin
      s1_v_r  <= pix_valid;
      s1_ac_r <= hit0 ? 8'h00 : (ovl_u[0] ? alpha1_r : alpha0_r); // RQ1 RQ2 RQ7
      s1_a1_r <= hit1 ? 8'h00 : (ovl_v[0] ? alpha1_r : alpha0_r); // RQ1 RQ2 RQ7
    end
  end

  // Sample pipeline copies
  always_ff @(posedge sys_clk)
  begin
    s1_img_r <= pix_in_image;
    s1_iy0_r <= img_y0;
    s1_iy1_r <= img_y1;
    s1_iu_r  <= img_u;
    s1_iv_r  <= img_v;
    s1_oy0_r <= ovl_y0;
    s1_oy1_r <= ovl_y1;
    s1_ou_r  <= ovl_u;
    s1_ov_r  <= ovl_v;
  end

  // Stage 2: blending
  logic       fine;
  logic [7:0] bl_y0, bl_y1, bl_u, bl_v;
  logic       s2_v_r;
  logic       s2_img_r;
  logic [7:0] s2_y0_r, s2_y1_r, s2_u_r, s2_v_comp_r;

  assign fine = enh_r[ENH_ON] && enh_r[ENH_BLEND]; // RQ25

  vcs_blend u_bl_y0 (.ovl(s1_oy0_r), .img(s1_iy0_r), .alpha(s1_ac_r), .fine(fine), .res(bl_y0));
  vcs_blend u_bl_u  (.ovl(s1_ou_r),  .img(s1_iu_r),  .alpha(s1_ac_r), .fine(fine), .res(bl_u));
  vcs_blend u_bl_v  (.ovl(s1_ov_r),  .img(s1_iv_r),  .alpha(s1_ac_r), .fine(fine), .res(bl_v));
  vcs_blend u_bl_y1 (.ovl(s1_oy1_r), .img(s1_iy1_r), .alpha(s1_a1_r), .fine(fine), .res(bl_y1));

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      s2_v_r <= 1'b0;
    else
      s2_v_r <= s1_v_r;
    s2_img_r    <= s1_img_r;
    s2_y0_r     <= bl_y0;
    s2_y1_r     <= bl_y1;
    s2_u_r      <= bl_u;
    s2_v_comp_r <= bl_v;
  end

  // Stage 3: clipping, fixed legacy limits unless programmed ones enabled and nonzero
  logic       clip_prog;
  logic [7:0] lo_y, hi_y, lo_c, hi_c;
  logic [7:0] cl_y0, cl_y1, cl_u, cl_v;

  assign clip_prog = clip_r != 32'h00000000 && enh_r[ENH_CLIP]; // RQ9
  assign lo_y = clip_prog ? clip_r[7:0]   : FIXED_FLOOR; // RQ13
  assign hi_y = clip_prog ? clip_r[15:8]  : FIXED_CEIL; // RQ13
  assign lo_c = clip_prog ? clip_r[23:16] : FIXED_FLOOR; // RQ13
  assign hi_c = clip_prog ? clip_r[31:24] : FIXED_CEIL; // RQ13

  vcs_clip u_cl_y0 (.val(s2_y0_r), .lo(lo_y), .hi(hi_y), .active(s2_img_r), .res(cl_y0)); // RQ10
  vcs_clip u_cl_y1 (.val(s2_y1_r), .lo(lo_y), .hi(hi_y), .active(s2_img_r), .res(cl_y1));
  vcs_clip u_cl_u  (.val(s2_u_r),  .lo(lo_c), .hi(hi_c), .active(s2_img_r), .res(cl_u));
  vcs_clip u_cl_v  (.val(s2_v_comp_r), .lo(lo_c), .hi(hi_c), .active(s2_img_r), .res(cl_v));

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_y0    <= 8'h00;
      out_y1    <= 8'h00;
      out_u     <= 8'h00;
      out_v     <= 8'h00;
    end
    else
    begin
      out_valid <= s2_v_r;
      out_y0    <= cl_y0;
      out_y1    <= cl_y1;
      out_u     <= cl_u;
      out_v     <= cl_v;
    end
  end

  // Checks on the flags and the datapath
  property p_unit_bit;
    @(posedge sys_clk) disable iff (rst) status[ST_UNIT] && (status[ST_HBE] == hbe_r);
  endproperty
  a_unit_bit: assert property (p_unit_bit) else $error("unit bit not fixed"); // RQ14

  property p_refill_underrun_refresh;
    @(posedge sys_clk) disable iff (rst) refresh && sav_pulse && b1_r |=> refill_underrun_r;
  endproperty
  a_refill_underrun_refresh: assert property (p_refill_underrun_refresh) else $error("underrun missed"); // RQ17

  property p_hbe;
    @(posedge sys_clk) disable iff (rst) highway_late |=> hbe_r [*2] or (hbe_r ##1 $fell(hbe_r));
  endproperty
  a_hbe: assert property (p_hbe) else $error("bandwidth error not raised"); // RQ21

  property p_sticky;
    @(posedge sys_clk) disable iff (rst) refill_underrun_r && !wr_ctl |=> refill_underrun_r;
  endproperty
  a_sticky: assert property (p_sticky) else $error("underrun cleared itself"); // RQ26

  property p_ack_clear;
    @(posedge sys_clk) disable iff (rst)
      wr_ctl && wb_sel_i[0] && wb_dat_i[CTL_BANDWIDTH_ERROR_CLEAR] && !highway_late |=> !hbe_r;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("acknowledge did not clear"); // RQ24

  property p_irq;
    @(posedge sys_clk) disable iff (rst) $rose(b1_r) && ctl_r[CTL_B1_IEN] |-> buf1_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("buffer interrupt missing"); // RQ20

  property p_fixed_clip;
    @(posedge sys_clk) disable iff (rst)
      s2_v_r && s2_img_r && !clip_prog |=> out_y0 >= FIXED_FLOOR && out_y0 <= FIXED_CEIL;
  endproperty
  a_fixed_clip: assert property (p_fixed_clip) else $error("legacy clip range broken"); // RQ13

  property p_key_transparent;
    @(posedge sys_clk) disable iff (rst)
      pix_valid && hit0 && !pix_in_image ##2 1'b1 |=> out_y0 == $past(img_y0, 3);
  endproperty
  a_key_transparent: assert property (p_key_transparent) else $error("keyed pixel not transparent"); // RQ7

  property p_stream_switch;
    @(posedge sys_clk) disable iff (rst) stream && last_byte_sent && !other_empty |=> act_r != $past(act_r);
  endproperty
  a_stream_switch: assert property (p_stream_switch) else $error("buffer did not switch"); // RQ18
endmodule
